// >>> core/p3qb_map.vh
`ifndef P3QB_MAP_VH
`define P3QB_MAP_VH
// ----------------------------------------
// Port three constants
// ----------------------------------------
`define P3QB_WIDTH 8
`define P3QB_LATCH_RESET 8'hff
`define P3QB_RESET_CYCLES 16
`define P3QB_BOOST_CYCLES 1
`define P3QB_BIT_RXD 0
`define P3QB_BIT_TXD 1
`define P3QB_BIT_IRQ0 2
`define P3QB_BIT_IRQ1 3
`define P3QB_BIT_T0 4
`define P3QB_BIT_T1 5
`define P3QB_BIT_WR 6
`define P3QB_BIT_RD 7
`endif

// >>> core/p3qb_reset_qual.v
`default_nettype none
// ----------------------------------------
// Reset pin qualifier
// ----------------------------------------
module p3qb_reset_qual #(
	parameter HOLD_CYCLES = 16
) (
	input wire clock,
	input wire rst,
	input wire resetPin,
	output reg deviceReset
);
	reg pinMeta;
	reg pinSync;
	reg [4:0] holdCount;
	// The last count is reached on the fifteenth high sample of the synchronised pin; the sixteenth asserts the reset
	localparam [4:0] HOLD_LAST = HOLD_CYCLES - 1;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			pinMeta <= 1'b0;
			pinSync <= 1'b0;
			holdCount <= 5'h00;
			deviceReset <= 1'b0;
		end else begin
			pinMeta <= resetPin;
			pinSync <= pinMeta;
			// Any low cycle restarts the count, so glitches never reset the core
			if (!pinSync) begin
				holdCount <= 5'h00;
				deviceReset <= 1'b0;
			end else if (holdCount != HOLD_LAST) begin
				holdCount <= holdCount + 5'h01;
				deviceReset <= 1'b0;
			end else begin
				deviceReset <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> core/p3qb_port.v
// Notes on behaviour
// - The core resets only after the reset pin stays high for 16 clock cycles in a row.
// - A pin whose latch holds one is only weakly pulled high and may be overridden outside.
// - Software writes one to a latch before using the pin as input, then reads the pin level.
// - A low-to-high output change turns on the strong pull-up for exactly one clock.
// - Each pin also carries a secondary function chosen by the peripheral that uses it.
// - Pin zero delivers serial receive data to the serial receiver.
// - Pin one carries the serial transmitter output.
// - Pin two feeds the first external interrupt and the timer zero gate.
// - Pin three feeds the second external interrupt and the timer one gate.
// - Pin four is the timer zero external count input.
// - Pin five is the timer one external count input.
// - Pin six is the write strobe under which external memory takes the port zero byte.
// - Pin seven is the read strobe under which external memory drives port zero.
`include "p3qb_map.vh"
`default_nettype none
module p3qb_port #(
	parameter WIDTH = `P3QB_WIDTH,
	parameter RESET_CYCLES = `P3QB_RESET_CYCLES
) (
	input wire clock,
	input wire rst,
	input wire resetPin,
	output reg coreReset,
	input wire [WIDTH-1:0] latchWriteData,
	input wire latchWrite,
	output reg [WIDTH-1:0] latchValue,
	output reg [WIDTH-1:0] pinReadValue,
	input wire [WIDTH-1:0] portThreePinsIn,
	output reg [WIDTH-1:0] portThreePinsPullDown,
	output reg [WIDTH-1:0] portThreePinsStrongUp,
	input wire serialTxData,
	input wire serialTxActive,
	output reg serialRxData,
	output reg extIrqZero,
	output reg extIrqOne,
	output reg timerZeroGate,
	output reg timerOneGate,
	output reg timerZeroCountIn,
	output reg timerOneCountIn,
	input wire extWriteStrobe,
	input wire extReadStrobe
);
	// ----------------------------------------
	// Reset qualifier
	// ----------------------------------------
	wire qualifiedReset;
	p3qb_reset_qual #(
		.HOLD_CYCLES(RESET_CYCLES)
	) resetQual (
		.clock(clock),
		.rst(rst),
		.resetPin(resetPin),
		.deviceReset(qualifiedReset)
	);
	// The port follows coreReset rather than the raw qualifier, so the latch
	// and the pins reinitialise on the edge that software sees the reset
	wire portReset;
	assign portReset = rst | coreReset;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			coreReset <= 1'b1;
		end else begin
			coreReset <= qualifiedReset;
		end
	end

	// ----------------------------------------
	// Secondary outputs
	// ----------------------------------------
	// Strobes arrive active high and pull their pin low; an idle secondary
	// output sits at one so that the latch alone sets the level
	reg [WIDTH-1:0] altOut;
	always @* begin
		altOut = {WIDTH{1'b1}};
		if (serialTxActive) begin
			altOut[`P3QB_BIT_TXD] = serialTxData;
		end
		if (extWriteStrobe) begin
			altOut[`P3QB_BIT_WR] = 1'b0;
		end
		if (extReadStrobe) begin
			altOut[`P3QB_BIT_RD] = 1'b0;
		end
	end

	// ----------------------------------------
	// Per-pin latch and drivers
	// ----------------------------------------
	localparam [WIDTH-1:0] LATCH_INIT = `P3QB_LATCH_RESET;
	wire [WIDTH-1:0] driveLevel;
	reg [WIDTH-1:0] lastDrive;
	genvar outIdx;
	generate
		for (outIdx = 0; outIdx < WIDTH; outIdx = outIdx + 1) begin : driveSlice
			reg next_latch;
			reg next_pullDown;
			reg next_strongUp;

			// Latch and secondary output meet as a wired AND on the pin
			assign driveLevel[outIdx] = latchValue[outIdx] & altOut[outIdx];

			always @* begin
				next_latch = latchValue[outIdx];
				if (latchWrite) begin
					next_latch = latchWriteData[outIdx];
				end
			end

			always @* begin
				// High pins rest on the weak pull-up so outside logic can win
				next_pullDown = ~driveLevel[outIdx];
				// Only a rising level boosts; lastDrive catches up one clock later
				next_strongUp = driveLevel[outIdx] & ~lastDrive[outIdx];
			end

			// A write lands on the next edge and reaches the pin one edge after
			always @(posedge clock or posedge portReset) begin
				if (portReset) begin
					latchValue[outIdx] <= LATCH_INIT[outIdx];
				end else begin
					latchValue[outIdx] <= next_latch;
				end
			end

			always @(posedge clock or posedge portReset) begin
				if (portReset) begin
					lastDrive[outIdx] <= LATCH_INIT[outIdx];
					portThreePinsPullDown[outIdx] <= 1'b0;
					portThreePinsStrongUp[outIdx] <= 1'b0;
				end else begin
					lastDrive[outIdx] <= driveLevel[outIdx];
					portThreePinsPullDown[outIdx] <= next_pullDown;
					portThreePinsStrongUp[outIdx] <= next_strongUp;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	// Pins are asynchronous to the core clock, so two stages come before any use
	// Only the second stage is read; the first may still be settling
	reg [WIDTH-1:0] pinMeta;
	reg [WIDTH-1:0] pinSync;

	genvar inIdx;
	generate
		for (inIdx = 0; inIdx < WIDTH; inIdx = inIdx + 1) begin : syncSlice
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					pinMeta[inIdx] <= 1'b1;
					pinSync[inIdx] <= 1'b1;
				end else begin
					pinMeta[inIdx] <= portThreePinsIn[inIdx];
					pinSync[inIdx] <= pinMeta[inIdx];
				end
			end

			// A read costs a third clock but keeps every user on one sample
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					pinReadValue[inIdx] <= 1'b1;
				end else begin
					pinReadValue[inIdx] <= pinSync[inIdx];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Serial receive
	// ----------------------------------------
	// Idles high like a stopped serial line
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			serialRxData <= 1'b1;
		end else begin
			serialRxData <= pinSync[`P3QB_BIT_RXD];
		end
	end

	// ----------------------------------------
	// Interrupts and timer gates
	// ----------------------------------------
	// Each request and its gate see the same sample so they never disagree
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			extIrqZero <= 1'b1;
			timerZeroGate <= 1'b1;
			extIrqOne <= 1'b1;
			timerOneGate <= 1'b1;
		end else begin
			extIrqZero <= pinSync[`P3QB_BIT_IRQ0];
			timerZeroGate <= pinSync[`P3QB_BIT_IRQ0];
			extIrqOne <= pinSync[`P3QB_BIT_IRQ1];
			timerOneGate <= pinSync[`P3QB_BIT_IRQ1];
		end
	end

	// ----------------------------------------
	// Timer count inputs
	// ----------------------------------------
	// Counters do their own edge detection on these levels
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			timerZeroCountIn <= 1'b1;
			timerOneCountIn <= 1'b1;
		end else begin
			timerZeroCountIn <= pinSync[`P3QB_BIT_T0];
			timerOneCountIn <= pinSync[`P3QB_BIT_T1];
		end
	end

endmodule
`default_nettype wire

// >>> sim/p3qb_monitor.sv
`default_nettype none
module p3qb_monitor #(
	parameter WIDTH = 8,
	parameter RESET_CYCLES = 4
) (
	input wire logic clock, rst, resetPin, coreReset, latchWrite, serialTxData, serialTxActive,
	input wire logic extWriteStrobe, extReadStrobe, serialRxData, extIrqZero, extIrqOne,
	input wire logic timerZeroGate, timerOneGate, timerZeroCountIn, timerOneCountIn,
	input wire logic [WIDTH-1:0] latchWriteData, latchValue, pinReadValue, portThreePinsIn,
	input wire logic [WIDTH-1:0] portThreePinsPullDown, portThreePinsStrongUp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (rst || coreReset);
	wire logic [7:0] up = portThreePinsStrongUp, dn = portThreePinsPullDown, pin = portThreePinsIn;
	wire logic [7:0] sec = {~extReadStrobe, ~extWriteStrobe, 4'hf, ~serialTxActive | serialTxData, 1'b1};
	boost_one_a: assert property ((up & $past(up)) == 8'h00) else $error("boost long");
	boost_cause_a: assert property (up == ($past(dn) & ~dn)) else $error("boost cause");
	latch_write_a: assert property (latchWrite |=> latchValue == $past(latchWriteData))
		else $error("latch write");
	drive_low_a: assert property (dn == ~$past(latchValue & sec)) else $error("drive");
	pin_read_a: assert property (pinReadValue == $past(pin, 3)) else $error("pin read");
	irq_gate_a: assert property ({extIrqOne, timerOneGate, extIrqZero, timerZeroGate}
		== $past({pin[3], pin[3], pin[2], pin[2]}, 3)) else $error("irq gate");
	count_in_a: assert property ({timerOneCountIn, timerZeroCountIn, serialRxData}
		== $past({pin[5:4], pin[0]}, 3)) else $error("count rx");
	qual_long_a: assert property (disable iff (rst)
		$rose(resetPin) ##0 resetPin[*8] |=> coreReset) else $error("no reset");
	qual_short_a: assert property (disable iff (rst) $rose(coreReset) |->
		$past(resetPin, 4) && $past(resetPin, 5) && $past(resetPin, 6) && $past(resetPin, 7))
		else $error("early reset");
	cover property (|up);
	cover property (disable iff (rst) $rose(coreReset));
	cover property ($past(extWriteStrobe) && dn[6]);
endmodule
bind p3qb_port p3qb_monitor #(.WIDTH(WIDTH), .RESET_CYCLES(RESET_CYCLES)) mon (.*);
`default_nettype wire

// >>> sim/p3qb_board.sv
`default_nettype none
module p3qb_board (
	input wire logic [7:0] pullDown,
	input wire logic [7:0] extLow,
	output wire logic [7:0] pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// Weak pull-up loses to a low driver on either side
	assign pins = ~(pullDown | extLow);
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, resetPin = 0, latchWrite = 0, serialTxData = 0, serialTxActive = 0;
	logic extWriteStrobe = 0, extReadStrobe = 0;
	logic [7:0] latchWriteData = 8'h00, extLow = 8'h00;
	wire logic coreReset, serialRxData, extIrqZero, extIrqOne, timerZeroGate, timerOneGate;
	wire logic timerZeroCountIn, timerOneCountIn;
	wire logic [7:0] latchValue, pinReadValue, portThreePinsIn, portThreePinsPullDown;
	wire logic [7:0] portThreePinsStrongUp;
	int num_errors = 0, checks = 0;
	// Short qualification keeps the run brief
	p3qb_port #(.RESET_CYCLES(4)) uut (.*);
	p3qb_board board (.pullDown(portThreePinsPullDown), .extLow(extLow), .pins(portThreePinsIn));
	initial forever #5 clock = ~clock;
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks=%0d errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(negedge clock);
	endtask
	task wr(input logic [7:0] d);
		latchWriteData = d;
		latchWrite = 1;
		step(1);
	endtask
	task t_boost;
		wr(8'h00);
		wr(8'h5a);
		latchWrite = 0;
		chk(portThreePinsPullDown, 8'hff);
		step(1);
		chk(portThreePinsStrongUp, 8'h5a);
		step(1);
		chk(portThreePinsStrongUp, 8'h00);
		wr(8'hff);
		latchWrite = 0;
		step(3);
		$display("boost done");
	endtask
	task t_input;
		logic [7:0] p;
		for (int i = 0; i < 3; i++) begin
			p = (i == 2) ? 8'hff : (i ? 8'h96 : 8'h69);
			extLow = ~p;
			step(4);
			chk(pinReadValue, p);
			chk({timerOneCountIn, timerZeroCountIn, timerOneGate, extIrqOne, timerZeroGate,
				extIrqZero, serialRxData}, {p[5:3], p[3:2], p[2], p[0]});
		end
		$display("input done");
	endtask
	task t_sec;
		serialTxActive = 1;
		extWriteStrobe = 1;
		step(1);
		chk(portThreePinsPullDown, 8'h42);
		serialTxData = 1;
		extWriteStrobe = 0;
		extReadStrobe = 1;
		step(1);
		chk(portThreePinsPullDown, 8'h80);
		chk(portThreePinsStrongUp, 8'h42);
		extReadStrobe = 0;
		serialTxActive = 0;
		step(2);
		$display("secondary done");
	endtask
	task t_reset;
		int n;
		wr(8'h00);
		latchWrite = 0;
		resetPin = 1;
		step(3);
		resetPin = 0;
		step(10);
		chk(coreReset, 1'b0);
		chk(latchValue, 8'h00);
		resetPin = 1;
		for (n = 0; n < 30 && coreReset !== 1'b1; n++) step(1);
		if (n == 30) begin
			num_errors++;
			wrap_up;
		end
		chk(8'(n), 8'd7);
		step(2);
		chk(coreReset, 1'b1);
		resetPin = 0;
		step(8);
		chk(coreReset, 1'b0);
		chk(latchValue, 8'hff);
		$display("reset done");
	endtask
	initial begin
		step(12);
		rst = 0;
		step(1);
		chk(latchValue, 8'hff);
		t_boost;
		t_input;
		t_sec;
		t_reset;
		wrap_up;
	end
endmodule
`default_nettype wire
